// File: src/flash_host_pkg.sv
// Constants shared by the flash pin controller and its testbench.
// Assumes a 100 MHz core clock; all pin timings are counted in it.
`default_nettype none
package flash_host_pkg;
	// ==========================================
	// Clock and pin timing
	localparam int CLK_PERIOD_NS          = 10;
	localparam int SELECT_ACCESS_TIME_NS  = 45;
	localparam int RESET_PULSE_WIDTH_NS   = 500;
	localparam int RESET_HIGH_TO_READ_NS  = 50;
	localparam int RESET_READY_NS         = 20000;
	localparam int ACCESS_CYC   = (SELECT_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RPULSE_CYC   = (RESET_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RHREAD_CYC   = (RESET_HIGH_TO_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READY_CYC    = (RESET_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W        = 16;
	// ==========================================
	// Controller register offsets
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] ADDR_OFS   = 8'h04;
	localparam logic [7:0] WDATA_OFS  = 8'h08;
	localparam logic [7:0] RDATA_OFS  = 8'h0c;
	localparam logic [7:0] STATUS_OFS = 8'h10;
	// CTRL fields
	localparam int CTRL_GO_BIT    = 0;
	localparam int CTRL_WRITE_BIT = 1;
	localparam int CTRL_RESET_BIT = 2;
	localparam int CTRL_WORD_BIT  = 3;
	localparam int CTRL_ID_BIT    = 4;
	localparam int CTRL_TOPB_BIT  = 5;
	localparam logic [31:0] CTRL_RESET_VAL = 32'h0000_0008;
	// STATUS fields
	localparam int ST_BUSY_BIT   = 0;
	localparam int ST_RYBY_BIT   = 1;
	localparam int ST_SECT_LSB   = 4;
	// ==========================================
	// Autoselect address fields
	localparam int AS_A6 = 6;
	localparam logic [1:0] AS_MFR  = 2'b00;
	localparam logic [1:0] AS_DEV  = 2'b01;
	localparam logic [1:0] AS_PROT = 2'b10;
	typedef enum logic [2:0] {
		ST_IDLE, ST_ACCESS, ST_WRITE, ST_RPULSE, ST_RWAIT, ST_RHREAD
	} fsm_t;
endpackage : flash_host_pkg
`default_nettype wire

// File: src/sector_decode.sv
// Sector number from address bits 17..12 for top- or bottom-boot parts.
// Assumes the part's boot variant is given by software.
`default_nettype none
module sector_decode (
	input  wire logic [5:0] a_hi,
	input  wire logic       top_boot,
	output logic      [3:0] sector
);
	// ==========================================
	// Decode; unlisted bits are don't-care
	always_comb begin
		sector = 4'h0;
		if (top_boot) begin
			if (a_hi[5:3] != 3'b111) sector = {1'b0, a_hi[5:3]};
			else if (!a_hi[2])       sector = 4'h7;
			else if (a_hi[1:0] == 2'b00) sector = 4'h8;
			else if (a_hi[1:0] == 2'b01) sector = 4'h9;
			else                     sector = 4'ha;
		end else begin
			if (a_hi[5:3] != 3'b000) sector = {1'b0, a_hi[5:3]} + 4'd3;
			else if (a_hi[2])        sector = 4'h3;
			else if (!a_hi[1])       sector = 4'h0;
			else if (!a_hi[0])       sector = 4'h1;
			else                     sector = 4'h2;
		end
	end
endmodule : sector_decode
`default_nettype wire

// File: src/flash_host.sv
// Host-side pin controller for a boot-sector parallel flash; AHB-Lite slave.
// Assumes the flash is the only device on its pins and holds its data pins per its modes.
// Functional notes
// - After standby exit wait full select access time before sampling data.
// - Software should restart interrupted program or erase after reset.
// - Wait reset-high-to-read delay before first read after reset.
// - Elevated voltage on address 9 enables equipment autoselect.
// - Autoselect: A6 low; A1:A0 select maker, device, protection.
`default_nettype none
module flash_host (
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic             chip_select_n,
	output logic             output_enable_n,
	output logic             write_enable_n,
	output logic             hw_reset_n,
	output logic             byte_mode_n,
	output logic      [17:0] addr,
	output logic             id_high_voltage,
	output logic      [15:0] data_o,
	output logic      [15:0] data_oe,
	input  wire logic [15:0] data_i,
	input  wire logic        ready_busy_n
);
	// ==========================================
	// Reset synchroniser
	logic rst_meta_q, rst_sync_q;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end
	wire logic rst_n = rst_sync_q;

	// ==========================================
	// Bus address phase capture
	logic       ph_valid_q, ph_write_q;
	logic [7:0] ph_addr_q;
	logic       ph_valid_d, ph_write_d;
	logic [7:0] ph_addr_d;
	always_comb begin
		ph_valid_d = hsel && htrans[1] && hready;
		ph_write_d = hwrite;
		ph_addr_d  = haddr[7:0];
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ph_valid_q <= 1'b0;
			ph_write_q <= 1'b0;
			ph_addr_q  <= 8'h00;
		end else begin
			ph_valid_q <= ph_valid_d;
			ph_write_q <= ph_write_d;
			ph_addr_q  <= ph_addr_d;
		end
	end

	// ==========================================
	// Registers and pin sequencer
	flash_host_pkg::fsm_t st_q, st_d;
	logic [31:0] ctrl_q, ctrl_d;
	logic [18:0] faddr_q, faddr_d;
	logic [15:0] wdat_q, wdat_d, rdat_q, rdat_d;
	logic [flash_host_pkg::CNT_W-1:0] cnt_q, cnt_d;
	logic [31:0] hrdata_d;
	logic [3:0]  sector;
	wire logic busy = (st_q != flash_host_pkg::ST_IDLE);
	wire logic wr_en = ph_valid_q && ph_write_q;
	wire logic word_md = ctrl_q[flash_host_pkg::CTRL_WORD_BIT];
	// Sector bits follow the pins: ADDR bit 0 is the extra low bit in byte mode
	wire logic [5:0] sect_bits = word_md ? faddr_q[17:12] : faddr_q[18:13];

	sector_decode u_dec (
		.a_hi     (sect_bits),
		.top_boot (ctrl_q[flash_host_pkg::CTRL_TOPB_BIT]),
		.sector   (sector)
	);

	always_comb begin
		st_d    = st_q;
		ctrl_d  = ctrl_q;
		faddr_d = faddr_q;
		wdat_d  = wdat_q;
		rdat_d  = rdat_q;
		cnt_d   = (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
		ctrl_d[flash_host_pkg::CTRL_GO_BIT]    = 1'b0;
		ctrl_d[flash_host_pkg::CTRL_RESET_BIT] = 1'b0;
		if (wr_en) begin
			unique case (ph_addr_q)
				flash_host_pkg::CTRL_OFS:  ctrl_d  = hwdata;
				flash_host_pkg::ADDR_OFS:  faddr_d = hwdata[18:0];
				flash_host_pkg::WDATA_OFS: wdat_d  = hwdata[15:0];
				default: ;
			endcase
		end
		unique case (st_q)
			flash_host_pkg::ST_IDLE: begin
				if (ctrl_q[flash_host_pkg::CTRL_RESET_BIT]) begin
					st_d  = flash_host_pkg::ST_RPULSE;
					cnt_d = flash_host_pkg::CNT_W'(flash_host_pkg::RPULSE_CYC);
				end else if (ctrl_q[flash_host_pkg::CTRL_GO_BIT]) begin
					if (ctrl_q[flash_host_pkg::CTRL_WRITE_BIT]) begin
						st_d  = flash_host_pkg::ST_WRITE;
						cnt_d = flash_host_pkg::CNT_W'(flash_host_pkg::ACCESS_CYC);
					end else begin
						st_d  = flash_host_pkg::ST_ACCESS;
						cnt_d = flash_host_pkg::CNT_W'(flash_host_pkg::ACCESS_CYC);
					end
				end
			end
			flash_host_pkg::ST_ACCESS: if (cnt_q == '0) begin
				// Autoselect returns only the low byte meaningfully
				if (ctrl_q[flash_host_pkg::CTRL_ID_BIT] || !word_md)
					rdat_d = {8'h00, data_i[7:0]};
				else
					rdat_d = data_i;
				st_d = flash_host_pkg::ST_IDLE;
			end
			flash_host_pkg::ST_WRITE: if (cnt_q == '0) st_d = flash_host_pkg::ST_IDLE;
			flash_host_pkg::ST_RPULSE: if (cnt_q == '0) begin
				st_d  = flash_host_pkg::ST_RWAIT;
				cnt_d = flash_host_pkg::CNT_W'(flash_host_pkg::READY_CYC);
			end
			// Wait busy to clear and the full idle completion time to elapse
			flash_host_pkg::ST_RWAIT: if (ready_busy_n && cnt_q == '0) begin
				st_d  = flash_host_pkg::ST_RHREAD;
				cnt_d = flash_host_pkg::CNT_W'(flash_host_pkg::RHREAD_CYC);
			end
			flash_host_pkg::ST_RHREAD: if (cnt_q == '0) st_d = flash_host_pkg::ST_IDLE;
			default: st_d = flash_host_pkg::ST_IDLE;
		endcase
		hrdata_d = 32'h0000_0000;
		unique case (ph_addr_d)
			flash_host_pkg::CTRL_OFS:   hrdata_d = ctrl_d;
			flash_host_pkg::ADDR_OFS:   hrdata_d = {13'h0000, faddr_d};
			flash_host_pkg::WDATA_OFS:  hrdata_d = {16'h0000, wdat_d};
			flash_host_pkg::RDATA_OFS:  hrdata_d = {16'h0000, rdat_d};
			flash_host_pkg::STATUS_OFS: hrdata_d = {24'h0, sector, 2'b00, ready_busy_n,
				(st_d != flash_host_pkg::ST_IDLE)};
			default: ;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q    <= flash_host_pkg::ST_IDLE;
			ctrl_q  <= flash_host_pkg::CTRL_RESET_VAL;
			faddr_q <= 19'h00000;
			wdat_q  <= 16'h0000;
			rdat_q  <= 16'h0000;
			cnt_q   <= '0;
			hrdata  <= 32'h0000_0000;
		end else begin
			st_q    <= st_d;
			ctrl_q  <= ctrl_d;
			faddr_q <= faddr_d;
			wdat_q  <= wdat_d;
			rdat_q  <= rdat_d;
			cnt_q   <= cnt_d;
			hrdata  <= hrdata_d;
		end
	end

	// ==========================================
	// Bus answer: zero wait, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// ==========================================
	// Pin drive; deselect between accesses is standby
	logic [17:0] addr_pin;
	always_comb begin
		addr_pin = word_md ? faddr_q[17:0] : faddr_q[18:1];
		if (ctrl_q[flash_host_pkg::CTRL_ID_BIT]) begin
			addr_pin[flash_host_pkg::AS_A6] = 1'b0;
			addr_pin[11:7] = 5'h00;                 // Don't-care bits 11..7 held quiet; 5..2 pass through
		end
	end
	assign addr            = addr_pin;
	assign chip_select_n   = !(st_q == flash_host_pkg::ST_ACCESS || st_q == flash_host_pkg::ST_WRITE);
	assign output_enable_n = (st_q != flash_host_pkg::ST_ACCESS);
	assign write_enable_n  = !(st_q == flash_host_pkg::ST_WRITE && cnt_q != '0);
	assign hw_reset_n      = (st_q != flash_host_pkg::ST_RPULSE);
	assign byte_mode_n     = word_md;
	// High voltage on A9 only for equipment-form identification
	assign id_high_voltage = ctrl_q[flash_host_pkg::CTRL_ID_BIT] && !busy ? 1'b0 :
		ctrl_q[flash_host_pkg::CTRL_ID_BIT];
	// Byte mode: DQ15 carries the lowest address bit, 8..14 undriven
	always_comb begin
		data_o  = 16'h0000;
		data_oe = 16'h0000;
		if (st_q == flash_host_pkg::ST_WRITE) begin
			data_o  = word_md ? wdat_q : {8'h00, wdat_q[7:0]};
			data_oe = word_md ? 16'hffff : 16'h00ff;
		end
		if (!word_md) begin
			data_o[15]  = faddr_q[0];
			data_oe[15] = 1'b1;
		end
	end

	// ==========================================
	// Checks
	property p_rpulse;
		@(posedge core_clk) disable iff (!rst_n)
		$fell(hw_reset_n) |-> !hw_reset_n [*8];
	endproperty
	a_rpulse: assert property (p_rpulse) else $error("reset pulse too short");
	property p_oe_cs;
		@(posedge core_clk) disable iff (!rst_n)
		!output_enable_n |-> !chip_select_n && hw_reset_n && write_enable_n;
	endproperty
	a_oe_cs: assert property (p_oe_cs) else $error("read without select");
	property p_access;
		@(posedge core_clk) disable iff (!rst_n)
		$fell(output_enable_n) |-> !output_enable_n [*5];
	endproperty
	a_access: assert property (p_access) else $error("read shorter than access time");
	property p_a6;
		@(posedge core_clk) disable iff (!rst_n)
		ctrl_q[flash_host_pkg::CTRL_ID_BIT] |-> !addr[flash_host_pkg::AS_A6];
	endproperty
	a_a6: assert property (p_a6) else $error("A6 high in autoselect");
	property p_rh;
		@(posedge core_clk) disable iff (!rst_n)
		$rose(hw_reset_n) |-> output_enable_n [*6];
	endproperty
	a_rh: assert property (p_rh) else $error("read too soon after reset");
	property p_busywait;
		@(posedge core_clk) disable iff (!rst_n)
		st_q == flash_host_pkg::ST_RWAIT && !ready_busy_n |=> st_q == flash_host_pkg::ST_RWAIT;
	endproperty
	a_busywait: assert property (p_busywait) else $error("left reset while busy");
	property p_byte15;
		@(posedge core_clk) disable iff (!rst_n)
		!byte_mode_n |-> data_oe[15] && data_oe[14:8] == 7'h00 && data_o[15] == faddr_q[0];
	endproperty
	a_byte15: assert property (p_byte15) else $error("byte mode pins wrong");
	property p_nowrite_oe;
		@(posedge core_clk) disable iff (!rst_n)
		!output_enable_n |-> data_oe[7:0] == 8'h00;
	endproperty
	a_nowrite_oe: assert property (p_nowrite_oe) else $error("drive during read");
endmodule : flash_host
`default_nettype wire

// File: tb/flash_model.sv
// Behavioural boot-sector flash part facing flash_host.
// Assumes the bench resolves the shared data lines and feeds them back on dq.
`default_nettype none
module flash_model #(
	parameter logic [7:0]  MFR_CODE  = 8'h5a, // Arbitrary value
	parameter logic [7:0]  DEV_CODE  = 8'h3c, // Arbitrary value
	parameter logic [10:0] PROT_MASK = 11'h425
) (
	input  wire logic        clk,
	input  wire logic        cs_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	input  wire logic        rst_n,
	input  wire logic        byte_n,
	input  wire logic        top,
	input  wire logic        id_hv,
	input  wire logic [17:0] a,
	input  wire logic [15:0] dq,
	output logic      [15:0] q,
	output logic      [15:0] q_oe,
	output logic             ryby_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [256];
	int          busy = 0;
	logic        we_q = 1'b1;
	// ==========================================
	// Sector decode
	function automatic logic [3:0] sect(input logic [5:0] h, input logic t);
		if (t)
			return (h[5:3] != 3'h7) ? {1'b0, h[5:3]} :
				!h[2] ? 4'h7 : !h[1] ? 4'h8 + 4'(h[0]) : 4'ha;
		return (h[5:2] == 4'h0) ? (h[1] ? 4'h1 + 4'(h[0]) : 4'h0) :
			(h[5:2] == 4'h1) ? 4'h3 : 4'h3 + 4'(h[5:3]);
	endfunction : sect
	// ==========================================
	// Read path: no mode latch, so array unless the id voltage is on with A6 low
	always_comb begin
		q = byte_n ? mem[a[7:0]] :
			{8'h00, dq[15] ? mem[a[7:0]][15:8] : mem[a[7:0]][7:0]};
		if (id_hv && !a[6]) begin
			case (a[1:0])
				2'b00: q = {8'h00, MFR_CODE};
				2'b01: q = {8'h00, DEV_CODE};
				2'b10: q = {15'h0, PROT_MASK[sect(a[17:12], top)]};
				default: q = 16'h0;
			endcase
		end
		// Floats in standby, reset and output disable
		q_oe = (!cs_n && !oe_n && rst_n) ? (byte_n ? 16'hffff : 16'h00ff) : 16'h0;
	end
	// Program store on the rising write strobe, seen at the clock; runs on when deselected
	// Reset aborts a program but stays busy until the abort settles
	always @(posedge clk) begin
		we_q <= we_n;
		if (we_n === 1'b1 && we_q === 1'b0 && !cs_n && rst_n) begin
			mem[a[7:0]] <= dq;
			busy <= 300;
		end else if (!rst_n && busy > 100)
			busy <= 100;
		else if (busy > 0)
			busy <= busy - 1;
	end
	assign ryby_n = (busy == 0);
endmodule : flash_model
`default_nettype wire

// File: tb/flash_host_tb_top.sv
// Self-checking bench for flash_host driving a behavioural flash part.
// Assumes the slave is alone on AHB-Lite, so hreadyout serves as hready.
`default_nettype none
module flash_host_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0]  CTRL = flash_host_pkg::CTRL_OFS;
	localparam logic [7:0]  ADDR = flash_host_pkg::ADDR_OFS;
	localparam logic [7:0]  STAT = flash_host_pkg::STATUS_OFS;
	localparam logic [7:0]  MFR  = 8'h5a; // Arbitrary value
	localparam logic [7:0]  DEV  = 8'h3c; // Arbitrary value
	localparam logic [10:0] PROT = 11'h425;
	logic        core_clk = 1'b0;
	logic        rstn     = 1'b0;
	logic        hsel     = 1'b0;
	logic        hwrite   = 1'b0;
	logic        top      = 1'b0;
	logic [1:0]  htrans   = 2'h0;
	logic [2:0]  hsize    = 3'h2;
	logic [31:0] haddr    = 32'h0;
	logic [31:0] hwdata   = 32'h0;
	logic [15:0] flt      = 16'h0;
	int          err_total = 0;
	int          samples_checked = 0;
	int          rlow = 0;
	wire logic [31:0] hrdata;
	wire logic        hreadyout, chip_select_n, output_enable_n, write_enable_n, hw_reset_n;
	wire logic        hresp;
	wire logic        byte_mode_n, id_high_voltage, ready_busy_n;
	wire logic [17:0] addr;
	wire logic [15:0] data_o, data_oe, data_i, fq, fq_oe;
	always #5 core_clk = ~core_clk;
	flash_host dut_u (
		.core_clk(core_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .chip_select_n(chip_select_n),
		.output_enable_n(output_enable_n), .write_enable_n(write_enable_n),
		.hw_reset_n(hw_reset_n), .byte_mode_n(byte_mode_n), .addr(addr),
		.id_high_voltage(id_high_voltage), .data_o(data_o), .data_oe(data_oe),
		.data_i(data_i), .ready_busy_n(ready_busy_n)
	);
	flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV), .PROT_MASK(PROT)) fm_u (
		.clk(core_clk), .cs_n(chip_select_n), .oe_n(output_enable_n), .we_n(write_enable_n),
		.rst_n(hw_reset_n), .byte_n(byte_mode_n), .top(top), .id_hv(id_high_voltage),
		.a(addr), .dq(data_i), .q(fq), .q_oe(fq_oe), .ryby_n(ready_busy_n)
	);
	// Undriven bits wander each cycle so a stale value never reads back
	assign data_i = (data_oe & data_o) | (~data_oe & fq_oe & fq) | (~data_oe & ~fq_oe & flt);
	// ==========================================
	// Tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Expected sector from the boot-block tables, independent of the part model
	function automatic logic [3:0] exp_sector(input logic [5:0] h, input logic t);
		logic [3:0] s;
		s = 4'h0;
		if (t)
			casez (h)
				6'b1110??: s = 4'h7;
				6'b111100: s = 4'h8;
				6'b111101: s = 4'h9;
				6'b11111?: s = 4'ha;
				default:   s = {1'b0, h[5:3]};
			endcase
		else
			casez (h)
				6'b00000?: s = 4'h0;
				6'b000010: s = 4'h1;
				6'b000011: s = 4'h2;
				6'b0001??: s = 4'h3;
				default:   s = 4'h3 + {1'b0, h[5:3]};
			endcase
		return s;
	endfunction : exp_sector
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		r = hrdata;
		chk(32'(hresp), 32'h0);
	endtask : bus
	// Start a flash cycle, wait for it to finish, fetch the read data
	task automatic op(input logic [31:0] c, output logic [31:0] r);
		logic [31:0] s;
		bus(1'b1, CTRL, c, s);
		repeat (3000) begin
			bus(1'b0, STAT, 32'h0, s);
			if (s[flash_host_pkg::ST_BUSY_BIT] === 1'b0)
				break;
		end
		chk(32'(s[flash_host_pkg::ST_BUSY_BIT]), 32'h0);
		bus(1'b0, flash_host_pkg::RDATA_OFS, 32'h0, r);
	endtask : op
	task automatic test_done();
		if (err_total == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : test_done
	// ==========================================
	// Pin watch: no drive fight, byte-mode float, reset pulse length
	always @(posedge core_clk) begin
		flt <= flt + 16'h1357;
		if (rstn) begin
			chk(32'(data_oe & fq_oe), 32'h0);
			if (byte_mode_n === 1'b0)
				chk(32'(data_oe[14:8]), 32'h0);
		end
		if (hw_reset_n === 1'b0)
			rlow <= rlow + 1;
		else if (rlow != 0) begin
			chk(32'(rlow >= flash_host_pkg::RPULSE_CYC), 32'h1);
			rlow <= 0;
		end
	end
	// Hang guard, far beyond the expected run length
	initial begin
		#500us;
		err_total++;
		test_done();
	end
	// ==========================================
	// Main sequence
	initial begin
		logic [31:0] r;
		logic [17:0] a;
		logic [15:0] d;
		r = $urandom(7);
		repeat (4) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge core_clk);
		bus(1'b0, CTRL, 32'h0, r);
		chk(r, flash_host_pkg::CTRL_RESET_VAL);
		bus(1'b0, 8'h14, 32'h0, r);
		chk(r, 32'h0);
		// Word program and read back, then the high byte in byte mode
		for (int i = 0; i < 6; i++) begin
			a = (i == 0) ? 18'h3ffff : 18'($urandom);
			d = 16'($urandom);
			bus(1'b1, ADDR, {14'h0, a}, r);
			bus(1'b1, flash_host_pkg::WDATA_OFS, {16'h0, d}, r);
			op(32'h0b, r);
			op(32'h09, r);
			chk(r, {16'h0, d});
			bus(1'b1, ADDR, {13'h0, a, 1'b1}, r);
			op(32'h01, r);
			chk(r, {24'h0, d[15:8]});
		end
		// Hardware reset while the part is still busy programming
		bus(1'b1, ADDR, {14'h0, a}, r);
		op(32'h0b, r);
		op(32'h0c, r);
		bus(1'b0, STAT, 32'h0, r);
		chk(32'(r[1:0]), 32'h2);
		op(32'h0b, r);
		op(32'h09, r);
		chk(r, {16'h0, d});
		// Every sector pattern in both boot variants, random don't-care bits
		for (int t = 0; t < 2; t++) begin
			top <= t[0];
			bus(1'b1, CTRL, {26'h0, t[0], 5'h08}, r);
			for (int h = 0; h < 64; h++) begin
				bus(1'b1, ADDR, {14'h0, h[5:0], 12'($urandom)}, r);
				bus(1'b0, STAT, 32'h0, r);
				chk(32'(r[7:4]), 32'(exp_sector(h[5:0], t[0])));
				a = {h[5:0], 5'($urandom), 1'b0, 4'($urandom), 2'b10};
				bus(1'b1, ADDR, {14'h0, a}, r);
				op({26'h0, t[0], 5'h19}, r);
				chk(32'(r[7:0]), 32'(PROT[exp_sector(h[5:0], t[0])]));
			end
			for (int c = 0; c < 2; c++) begin
				bus(1'b1, ADDR, {14'h0, 11'($urandom), 1'b0, 4'($urandom), 1'b0, c[0]}, r);
				op({26'h0, t[0], 5'h19}, r);
				chk(32'(r[7:0]), c ? 32'(DEV) : 32'(MFR));
			end
		end
		test_done();
	end
endmodule : flash_host_tb_top
`default_nettype wire
